// ===== rtl/sac_pkg.sv
// package of register map, fields and timing for the adc control block
package sac_pkg;
  localparam int DATA_W = 10;
  localparam int NUM_CH = 8;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'hD0;
  localparam logic [7:0] OFS_RESULT_LOW = 8'hD1;
  localparam logic [7:0] OFS_CONTROL = 8'hD2;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int START_BIT = 0;
  localparam int CLKSEL_LSB = 1;
  localparam int EOC_BIT = 3;
  localparam int CHAN_LSB = 4;
  localparam logic [9:0] SAR_MID = 10'h200;
  localparam int SETUP_CLKS = 10;
  localparam int BIT_CLKS = 4;
  localparam logic [1:0] CLK_DIV16 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV4 = 2'h2;
  localparam logic [3:0] DIV16_TC = 4'hF;
  localparam logic [3:0] DIV8_TC = 4'h7;
  localparam logic [3:0] DIV4_TC = 4'h3;
  localparam logic [3:0] DIV1_TC = 4'h0;
  typedef enum {ST_IDLE, ST_SETUP, ST_BITS} sac_state_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sac_bus_t;
  typedef struct packed {
    logic [9:0] trial;
    logic [2:0] chan;
  } sac_analog_t;
endpackage

// ===== rtl/sac_adc_control.sv
// successive-approximation adc sequencer with control and result registers
// Behaviour
// - sar loads mid-scale 200h at the start of each conversion
// - control bits 6:4 pick one of eight analog inputs
// - writing start bit 1 launches conversion; 0 disables operation
// - on finish set end-of-conversion flag and store ten-bit result
// - end-of-conversion flag is read-only: 0 while busy, 1 when done
// - after storing result return idle until started again
// - only one result held; next conversion overwrites it
// - clock field 2:1 selects sysclk/16, /8, /4 or /1
// - four conversion clocks per bit decision
// - ten set-up conversion clocks; fifty clocks per conversion
// - resolve msb first; first trial is half reference
// - one channel at a time, ten-bit result per conversion
// - per-pin analog enable routes pin to the input multiplexer
// - reset clears control to zero
// - bit 7 reads 0; result registers read-only, reset to zero
`timescale 1ns/100ps
`default_nettype none
module sac_adc_control
  import sac_pkg::*;
#(
  parameter int NUM_PINS = 8
)(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  // register port
  input wire sac_pkg::sac_bus_t BUS_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // pin analog enables and digital pin levels
  input wire logic [NUM_PINS-1:0] ANALOG_INPUT_ENABLE_IN,
  input wire logic [NUM_PINS-1:0] PIN_LEVEL_IN,
  output logic [NUM_PINS-1:0] DIGITAL_PIN_OUT,
  // analog side: comparator says input is at or above trial level
  input wire logic COMP_IN,
  output var sac_pkg::sac_analog_t ANALOG_OUT,
  output logic MUX_CONNECT_OUT
);
  import sac_pkg::*;

  // timing: a conversion clock tick comes every 1, 4, 8 or 16 core clocks;
  // set-up takes ten ticks and each bit four, so a conversion is fifty ticks.
  // limitation: the input is compared once per bit with no hold stage, so
  // the source must stay still for the whole conversion.
  // a start write while busy does not restart, but rewrites the channel and clock fields and the new clock select applies at once; stop first to restart.

  sac_state_t state_q;
  sac_state_t state_d;
  localparam logic [3:0] MSB_IDX = 4'(DATA_W - 1);
  logic [2:0] chan_q;
  logic [1:0] clksel_q;
  logic start_q;
  logic eoc_q;
  logic [2:0] conv_chan_q;
  logic [9:0] sar_q;
  logic [7:0] result_hi_q;
  logic [1:0] result_lo_q;
  logic [3:0] div_q;
  logic [3:0] step_q;
  logic [3:0] bitidx_q;
  logic [7:0] rdata_q;
  logic [NUM_PINS-1:0] dig_q;
  logic mux_q;

  // register decode
  wire hit_high = (BUS_IN.addr == OFS_RESULT_HIGH);
  wire hit_low = (BUS_IN.addr == OFS_RESULT_LOW);
  wire hit_ctrl = (BUS_IN.addr == OFS_CONTROL);
  wire wr_ctrl = BUS_IN.wr && hit_ctrl;
  wire start_wr = wr_ctrl && BUS_IN.wdata[START_BIT];
  wire stop_wr = wr_ctrl && !BUS_IN.wdata[START_BIT];
  wire [2:0] wr_chan = BUS_IN.wdata[CHAN_LSB +: 3];
  wire [1:0] wr_clksel = BUS_IN.wdata[CLKSEL_LSB +: 2];
  wire in_idle = (state_q == ST_IDLE);
  wire in_setup = (state_q == ST_SETUP);
  wire in_bits = (state_q == ST_BITS);
  // divider terminal count per clock select
  wire sel_div16 = (clksel_q == CLK_DIV16);
  wire sel_div8 = (clksel_q == CLK_DIV8);
  wire sel_div4 = (clksel_q == CLK_DIV4);
  wire [3:0] div_tc = sel_div16 ? DIV16_TC :
                      sel_div8 ? DIV8_TC :
                      sel_div4 ? DIV4_TC : DIV1_TC;
  wire conv_tick = (div_q == div_tc);
  wire setup_done = in_setup && conv_tick && (step_q == 4'(SETUP_CLKS - 1));
  wire bit_done = in_bits && conv_tick && (step_q == 4'(BIT_CLKS - 1));
  // the step counter is shared, so each phase may only end its own count
  wire count_clear = in_idle || setup_done || bit_done;
  wire last_bit = (bitidx_q == 4'h0);
  // bit under trial is kept if the input is not below the trial level
  wire [9:0] cur_mask = 10'h001 << bitidx_q;
  wire [9:0] decided = COMP_IN ? sar_q : (sar_q & ~cur_mask);
  wire [9:0] next_trial = decided | (cur_mask >> 1);
  wire finish = bit_done && last_bit;
  wire sar_load = in_idle && start_wr;
  wire sar_step = bit_done;
  // a finish in the same cycle as a start write still reports completion
  wire eoc_d = finish || (eoc_q && !start_wr);
  wire start_d = wr_ctrl ? BUS_IN.wdata[START_BIT] : (start_q && !finish);
  // channel is frozen while converting so one input feeds a whole conversion
  wire conv_chan_load = wr_ctrl && (in_idle || stop_wr);
  wire [7:0] ctrl_view = {1'b0, chan_q, eoc_q, clksel_q, start_q};
  wire [7:0] rd_high = result_hi_q;
  wire [7:0] rd_low = {6'h00, result_lo_q};
  wire [7:0] rd_mux = hit_high ? rd_high :
                      hit_low ? rd_low :
                      hit_ctrl ? ctrl_view :
                      BYTE_ZERO;

  // next state: a zero start write aborts from either busy state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_wr)
          state_d = ST_SETUP;
      end
      ST_SETUP:
      begin
        if (stop_wr)
          state_d = ST_IDLE;
        else if (setup_done)
          state_d = ST_BITS;
      end
      ST_BITS:
      begin
        if (stop_wr || finish)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // channel and clock fields change only on a control write
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      chan_q <= CONTROL_RST[CHAN_LSB +: 3];
      clksel_q <= CONTROL_RST[CLKSEL_LSB +: 2];
    end
    else if (wr_ctrl)
    begin
      chan_q <= wr_chan;
      clksel_q <= wr_clksel;
    end
  end

  // converting channel, loaded between conversions or on an abort
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      conv_chan_q <= CONTROL_RST[CHAN_LSB +: 3];
    else if (conv_chan_load)
      conv_chan_q <= wr_chan;
  end

  // start bit follows software and drops by itself at the finish
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      start_q <= CONTROL_RST[START_BIT];
    else
      start_q <= start_d;
  end

  // hardware-owned flag: software writes to this bit have no effect
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      eoc_q <= CONTROL_RST[EOC_BIT];
    else
      eoc_q <= eoc_d;
  end

  // divider restarts with each conversion and at every conversion-clock tick
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      div_q <= 4'h0;
    else if (in_idle || conv_tick)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  // step counts conversion clocks within set-up or within one bit decision
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      step_q <= 4'h0;
    else if (count_clear)
      step_q <= 4'h0;
    else if (conv_tick)
      step_q <= step_q + 4'h1;
  end

  // trial register: mid-scale first, then one decision per bit period
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      sar_q <= SAR_MID;
    else if (sar_load)
      sar_q <= SAR_MID;
    else if (sar_step)
      sar_q <= last_bit ? decided : next_trial;
  end

  // bit index walks from the msb down to the lsb
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      bitidx_q <= MSB_IDX;
    else if (sar_load)
      bitidx_q <= MSB_IDX;
    else if (sar_step)
      bitidx_q <= bitidx_q - 4'h1;
  end

  // single result, high byte: overwritten by every finish
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      result_hi_q <= BYTE_ZERO;
    else if (finish)
      result_hi_q <= decided[9:2];
  end

  // low byte keeps only the two least significant result bits
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      result_lo_q <= 2'h0;
    else if (finish)
      result_lo_q <= decided[1:0];
  end

  wire [NUM_PINS-1:0] dig_d;
  wire [NUM_PINS-1:0] pin_hit;
  // per-pin routing: an analog-enabled pin leaves the digital path
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pin
    assign dig_d[p] = PIN_LEVEL_IN[p] && !ANALOG_INPUT_ENABLE_IN[p];
    assign pin_hit[p] = ANALOG_INPUT_ENABLE_IN[p] && (conv_chan_q == 3'(p));
  end
  // connect only while converting, so an idle channel is never loaded
  wire mux_d = !in_idle && (|pin_hit);

  // read data is zero outside a read cycle
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      rdata_q <= BYTE_ZERO;
    else
      rdata_q <= RD_IN ? rd_mux : BYTE_ZERO;
  end

  // digital readback only for pins not handed to the converter
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      dig_q <= '0;
    else
      dig_q <= dig_d;
  end

  // registered so the switch control never glitches during decode
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      mux_q <= 1'b0;
    else
      mux_q <= mux_d;
  end

  // trial and channel leave through a register, one cycle behind the sar
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      ANALOG_OUT <= '0;
    else
    begin
      ANALOG_OUT.trial <= sar_q;
      ANALOG_OUT.chan <= conv_chan_q;
    end
  end

  assign RDATA_OUT = rdata_q;
  assign DIGITAL_PIN_OUT = dig_q;
  assign MUX_CONNECT_OUT = mux_q;
endmodule
`default_nettype wire

// ===== verif/sac_comp_model.sv
// comparator and dac model: each channel sits at a fixed level
`timescale 1ns/100ps
`default_nettype none
module sac_comp_model
  import sac_pkg::*;
(
  // trial from the converter
  input wire sac_pkg::sac_analog_t ana_in,
  // decision back
  output logic comp_out
);
  // level is {channel, 2Bh}; odd lsb means the last bit keeps the trial
  assign comp_out = {ana_in.chan, 7'h2B} >= ana_in.trial;
endmodule
`default_nettype wire

// ===== verif/sac_adc_control_sva.sv
// assertions on the adc control block ports
`timescale 1ns/100ps
`default_nettype none
module sac_adc_control_sva
  import sac_pkg::*;
#(
  parameter int NUM_PINS = 8
)(
  // watched ports
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire sac_pkg::sac_bus_t BUS_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [NUM_PINS-1:0] ANALOG_INPUT_ENABLE_IN,
  input wire logic [NUM_PINS-1:0] PIN_LEVEL_IN,
  input wire logic [NUM_PINS-1:0] DIGITAL_PIN_OUT,
  input wire sac_pkg::sac_analog_t ANALOG_OUT,
  input wire logic MUX_CONNECT_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  wire ctl_wr = BUS_IN.wr && BUS_IN.addr == OFS_CONTROL;
  sequence setup_mid;
    ##2 (ANALOG_OUT.trial == SAR_MID) [*8];
  endsequence
  AST_IDLE_RD: assert property (!RD_IN |=> RDATA_OUT == BYTE_ZERO)
    else $error("read data not zero");
  AST_RSV_BIT: assert property (RD_IN && BUS_IN.addr == OFS_CONTROL |=> !RDATA_OUT[7])
    else $error("reserved bit set");
  AST_LOW_PAD: assert property (RD_IN && BUS_IN.addr == OFS_RESULT_LOW |=> RDATA_OUT[7:2] == 6'h00)
    else $error("low byte padding");
  AST_DIG_PIN: assert property (1'h1 |=> DIGITAL_PIN_OUT ==
    ($past(PIN_LEVEL_IN) & ~$past(ANALOG_INPUT_ENABLE_IN))) else $error("digital pin");
  AST_MUX_ENA: assert property (MUX_CONNECT_OUT |-> ANALOG_INPUT_ENABLE_IN[ANALOG_OUT.chan])
    else $error("mux on a digital pin");
  AST_CHAN: assert property (ctl_wr && !(MUX_CONNECT_OUT && BUS_IN.wdata[START_BIT])
    |=> ##1 ANALOG_OUT.chan == $past(BUS_IN.wdata[6:4], 2)) else $error("channel select");
  AST_MID: assert property (ctl_wr && BUS_IN.wdata[START_BIT] && !MUX_CONNECT_OUT |=> setup_mid)
    else $error("trial not mid-scale in set-up");
  AST_BIT_HOLD: assert property ($changed(ANALOG_OUT.trial) && ANALOG_OUT.trial != SAR_MID
    |=> $stable(ANALOG_OUT.trial) [*3]) else $error("bit period short");
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the adc control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sac_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic rd = 1'h0;
  sac_bus_t bus = '0;
  logic [7:0] ena = 8'hFF;
  logic [7:0] pins = 8'h00;
  logic [7:0] rdata;
  logic [7:0] dig;
  logic comp;
  logic mux;
  sac_analog_t ana;
  int mismatches = 0;
  int checked = 0;
  always #50 clk = ~clk;
  sac_adc_control sac_adc_control_inst (.CORE_CLK_IN(clk), .NRST_IN(nrst), .BUS_IN(bus),
    .RD_IN(rd), .RDATA_OUT(rdata), .ANALOG_INPUT_ENABLE_IN(ena), .PIN_LEVEL_IN(pins),
    .DIGITAL_PIN_OUT(dig), .COMP_IN(comp), .ANALOG_OUT(ana), .MUX_CONNECT_OUT(mux));
  sac_comp_model sac_comp_model_inst (.ana_in(ana), .comp_out(comp));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{1'h1, a, d};
    @(posedge clk);
    bus.wr <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus.addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk("rdata", exp, rdata);
  endtask
  task automatic t_regs;
    rdc(OFS_CONTROL, CONTROL_RST);
    rdc(OFS_RESULT_LOW, BYTE_ZERO);
    wr(OFS_RESULT_HIGH, 8'hFF);
    rdc(OFS_RESULT_HIGH, BYTE_ZERO);
    wr(OFS_CONTROL, 8'hFE);
    rdc(OFS_CONTROL, 8'h76);
    rdc(8'h40, BYTE_ZERO);
    @(posedge clk);
    ena <= 8'h0F;
    pins <= 8'hA5;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("pins", 8'hA0, dig);
    @(posedge clk);
    ena <= 8'hFF;
    $display("registers and pins done");
  endtask
  task automatic t_conv(input logic [2:0] ch, input logic [1:0] cs);
    int n;
    logic [9:0] lvl;
    // conversion ends 50 conversion clocks plus one cycle after the start write
    n = 50 * (cs == 2'h3 ? 1 : 16 >> cs) + 1;
    lvl = {ch, 7'h2B};
    wr(OFS_CONTROL, {1'h0, ch, 1'h0, cs, 1'h1});
    repeat (n - 4) @(posedge clk);
    rdc(OFS_CONTROL, {1'h0, ch, 1'h0, cs, 1'h1});
    chk("mux", 8'h01, {7'h00, mux});
    chk("chan", {5'h00, ch}, {5'h00, ana.chan});
    repeat (2) @(posedge clk);
    rdc(OFS_CONTROL, {1'h0, ch, 1'h1, cs, 1'h0});
    rdc(OFS_RESULT_HIGH, lvl[9:2]);
    rdc(OFS_RESULT_LOW, {6'h00, lvl[1:0]});
    chk("trial", lvl[9:2], ana.trial[9:2]);
    chk("mux idle", 8'h00, {7'h00, mux});
    $display("conversion ch %0d clk %0d done", ch, cs);
  endtask
  task automatic t_abort;
    wr(OFS_CONTROL, 8'h27);
    repeat (20) @(posedge clk);
    wr(OFS_CONTROL, 8'h26);
    repeat (60) @(posedge clk);
    rdc(OFS_CONTROL, 8'h26);
    chk("mux abort", 8'h00, {7'h00, mux});
    rdc(OFS_RESULT_HIGH, 8'hEA);
    $display("abort done");
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #1000000;
    mismatches++;
    end_of_test;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    t_regs;
    for (int c = 0; c < 8; c++)
      t_conv(c[2:0], 2'h3);
    t_abort;
    for (int k = 0; k < 3; k++)
      t_conv(3'h5, k[1:0]);
    end_of_test;
  end
endmodule
bind sac_adc_control sac_adc_control_sva #(.NUM_PINS(NUM_PINS)) sac_adc_control_sva_inst (
  .CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN), .BUS_IN(BUS_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .ANALOG_INPUT_ENABLE_IN(ANALOG_INPUT_ENABLE_IN),
  .PIN_LEVEL_IN(PIN_LEVEL_IN), .DIGITAL_PIN_OUT(DIGITAL_PIN_OUT), .ANALOG_OUT(ANALOG_OUT),
  .MUX_CONNECT_OUT(MUX_CONNECT_OUT));
`default_nettype wire
